// file: ticket_cfg.svh
// Purpose: constants of the ticket command link (opcodes, lengths, codes)
// Assumes: included by bare name from the package and the two ends
// Notes: the timeout count derives from the reference clock rate below
`ifndef TICKET_CFG_SVH
`define TICKET_CFG_SVH

// opcodes of the handled commands
`define OP_INCR 8'hA5
`define OP_COUNTER_READ_CMD 8'h39
`define OP_AUTH 8'h1B
`define OP_SIG 8'h3C
`define OP_TEAR 8'h3E
`define OP_VCS 8'h4B

// frame lengths without crc, opcode byte included
`define LEN_INCR 5'h06
`define LEN_IDX 5'h02
`define LEN_AUTH 5'h05
`define LEN_VCS 5'h15
`define RX_MAX 5'h15

// reply sizes and values
`define LEN_CNT_REPLY 6'h03
`define LEN_PACK_REPLY 6'h02
`define LEN_SIG_REPLY 6'h20
`define LEN_BYTE_REPLY 6'h01
`define CNT_IDX_MAX 8'h02
`define SIG_ARG 8'h00
`define TEAR_OK 8'hBD
`define TEAR_BAD 8'h00
`define CNT_RST 24'h000000
`define FAIL_RST 3'h0

// four-bit answer codes
`define ACK_CODE 4'hA
`define NAK_ARG 4'h0
`define NAK_CRC 4'h1
`define NAK_AUTH 4'h4

// timing: turnaround in link cycles, timeout in microseconds
`define TURN_MIN 4'h9
`define TIMEOUT_US 32'd5000
`define REF_MHZ 32'd10
`define FIELD_RST_LEN 3'h7

`endif

// file: ticket_pkg.sv
// Purpose: shared types of the ticket command link
// Assumes: ticket_cfg.svh holds every number
// Notes: card state is one packed struct
`include "ticket_cfg.svh"
package ticket_pkg;

    typedef logic [20:0][7:0] rx_buf_t;   // command frame bytes
    typedef logic [31:0][7:0] sig_t;      // 32-byte signature
    typedef logic [2:0][23:0] cnt_arr_t;  // three one-way counters

    // card sequencer states
    typedef enum logic [2:0] {
        C_IDLE = 3'b001,
        C_WAIT = 3'b010,
        C_SEND = 3'b100
    } card_state_t;

    // reader sequencer states
    typedef enum logic [2:0] {
        R_IDLE = 3'b001,
        R_SEND = 3'b010,
        R_WAIT = 3'b100
    } reader_state_t;

    // deferred nonvolatile update
    typedef enum logic [2:0] {
        P_NONE = 3'b001,
        P_INCR = 3'b010,
        P_FAIL = 3'b100
    } pend_t;

    typedef struct packed {
        card_state_t st;
        rx_buf_t rx;
        logic [4:0] rx_cnt;
        logic [3:0] wait_cnt;
        pend_t pend;
        logic [23:0] new_val;
        logic short_rep;
        logic [3:0] code;
        logic [5:0] tx_len;
        logic [5:0] tx_idx;
        logic gap;
        logic tog;
        logic [7:0] dout;
        logic dshort;
        logic dlast;
        logic authed;
        logic [1:0] pf_sync;
        logic rd_ok;
        logic wr_ok;
        logic locked;
        cnt_arr_t cnt;
        logic [2:0] torn;
        logic [2:0] fail_cnt;
    } card_t;

    typedef struct packed {
        reader_state_t st;
        logic lclk;
        logic frst;
        logic [2:0] frst_cnt;
        logic rdv;
        logic [7:0] rdd;
        logic rde;
        logic rdc;
        rx_buf_t cbuf;
        logic [4:0] len;
        logic [4:0] idx;
        logic crc_bad;
        logic [31:0] tmo;
        logic [2:0] tog_sync;
        logic ready;
        logic rvalid;
        logic rshort;
        logic [3:0] rcode;
        logic [5:0] rlen;
        sig_t rdata;
        logic rtimeout;
    } reader_t;

endpackage : ticket_pkg

// file: ticket_link_if.sv
// Purpose: byte-level link between reader and card
// Assumes: reader makes link_clk and field_rst
// Notes: card bytes are marked by a toggle, data held until next toggle
`timescale 1ns/1ps
interface ticket_link_if;
    logic link_clk;       // link clock from the reader divider
    logic field_rst;      // field power-up reset, high active
    logic rd_valid;       // reader byte strobe
    logic [7:0] rd_data;  // reader byte
    logic rd_end;         // end of reader frame
    logic rd_crc_err;     // frame crc was bad, with rd_end
    logic dv_tog;         // card byte toggle
    logic [7:0] dv_data;  // card byte or 4-bit code in low nibble
    logic dv_short;       // byte is a 4-bit ack or nak
    logic dv_last;        // last byte of the answer

    modport card (
        input link_clk, field_rst, rd_valid, rd_data, rd_end, rd_crc_err,
        output dv_tog, dv_data, dv_short, dv_last
    );
    modport reader (
        output link_clk, field_rst, rd_valid, rd_data, rd_end, rd_crc_err,
        input dv_tog, dv_data, dv_short, dv_last
    );
endinterface : ticket_link_if

// file: ticket_card.sv
// Purpose: card-side command handler for counter, password, signature
// Assumes: config inputs are static or in the link clock domain
// Notes: counters and failure count survive field reset
`timescale 1ns/1ps
`include "ticket_cfg.svh"

////////////////////////////////////////////////////////////////////////
module ticket_card
    import ticket_pkg::*;
#(
    parameter sig_t SIGNATURE = {32{8'h5A}}  // arbitrary value
)
(
    ticket_link_if.card link,
    input wire logic factory_clear,
    input wire logic power_fail,
    input wire logic [7:0] protection_start_page,
    input wire logic protection_scope_bit,
    input wire logic [2:0] failed_attempt_limit,
    input wire logic [31:0] password,
    input wire logic [15:0] pack,
    input wire logic [7:0] virtual_card_type,
    input wire logic [7:0] query_page,
    output logic query_read_ok,
    output logic query_write_ok,
    output logic authenticated,
    output logic access_locked,
    output logic [2:0] tear_flags
);

    ////////////////////////////////////////////////////////////////////
    // state
    card_t s;       // registered state
    card_t next_s;  // next state

    // link outputs and user outputs straight from flops
    assign link.dv_tog = s.tog;
    assign link.dv_data = s.dout;
    assign link.dv_short = s.dshort;
    assign link.dv_last = s.dlast;
    assign query_read_ok = s.rd_ok;
    assign query_write_ok = s.wr_ok;
    assign authenticated = s.authed;
    assign access_locked = s.locked;
    assign tear_flags = s.torn;

    ////////////////////////////////////////////////////////////////////
    // next-state logic
    always_comb
    begin
        logic [7:0] op;          // opcode byte
        logic [1:0] ci;          // counter index
        logic idx_ok;            // index in range
        logic [23:0] addend;     // increment value
        logic [24:0] sum;        // counter plus addend with carry
        logic [23:0] cur;        // addressed counter
        logic [7:0] rb;          // data byte of the answer
        logic pw_ok;             // password match
        logic limited;           // failure limit active
        logic protected_page;    // queried page in protected area
        op = s.rx[0];
        ci = s.rx[1][1:0];
        idx_ok = (s.rx[1] <= `CNT_IDX_MAX);
        // low byte first, fourth byte ignored
        addend = {s.rx[4], s.rx[3], s.rx[2]};
        cur = s.cnt[ci];
        sum = {1'b0, cur} + {1'b0, addend};
        pw_ok = ({s.rx[4], s.rx[3], s.rx[2], s.rx[1]} == password);
        limited = (failed_attempt_limit != 3'h0);
        protected_page = (query_page >= protection_start_page);
        next_s = s;

        // factory erase first, so a tear or commit this cycle still lands
        if (factory_clear)
        begin
            next_s.cnt = {3{`CNT_RST}};
            next_s.torn = 3'h0;
            next_s.fail_cnt = `FAIL_RST;
        end

        // answer byte source by opcode
        unique case (op)
            `OP_COUNTER_READ_CMD: rb = cur[{s.tx_idx[1:0], 3'b000} +: 8];
            `OP_AUTH: rb = pack[{s.tx_idx[0], 3'b000} +: 8];
            `OP_SIG: rb = SIGNATURE[s.tx_idx[4:0]];
            `OP_TEAR: rb = s.torn[ci] ? `TEAR_BAD : `TEAR_OK;
            default: rb = virtual_card_type;
        endcase

        // power fail input passes two flops
        next_s.pf_sync = {s.pf_sync[0], power_fail};

        // protection view of a queried page
        next_s.rd_ok = !(protected_page && protection_scope_bit
                         && !s.authed);
        next_s.wr_ok = !(protected_page && !s.authed);
        next_s.locked = limited
                        && (s.fail_cnt >= failed_attempt_limit);

        unique case (s.st)
            C_IDLE:
            begin
                // collect frame bytes, overlong frames marked
                if (link.rd_valid)
                begin
                    if (s.rx_cnt < `RX_MAX)
                    begin
                        next_s.rx[s.rx_cnt] = link.rd_data;
                        next_s.rx_cnt = s.rx_cnt + 5'h01;
                    end
                    else
                    begin
                        next_s.rx_cnt = `RX_MAX + 5'h01;
                    end
                end
                else if (link.rd_end)
                begin
                    // decode at frame end, default answer is nak
                    next_s.short_rep = 1'b1;
                    next_s.code = `NAK_ARG;
                    next_s.tx_len = `LEN_BYTE_REPLY;
                    next_s.pend = P_NONE;
                    next_s.st = C_WAIT;
                    next_s.wait_cnt = 4'h0;
                    if (link.rd_crc_err)
                    begin
                        next_s.code = `NAK_CRC;
                    end
                    else
                    begin
                        unique case (op)
                            `OP_INCR:
                            begin
                                if (s.rx_cnt == `LEN_INCR && idx_ok)
                                begin
                                    if (sum[24])
                                    begin
                                        next_s.code = `NAK_ARG;
                                    end
                                    else
                                    begin
                                        // zero addend commits same value
                                        next_s.pend = P_INCR;
                                        next_s.new_val = sum[23:0];
                                        next_s.code = `ACK_CODE;
                                    end
                                end
                            end
                            `OP_COUNTER_READ_CMD:
                            begin
                                if (s.rx_cnt == `LEN_IDX && idx_ok)
                                begin
                                    next_s.short_rep = 1'b0;
                                    next_s.tx_len = `LEN_CNT_REPLY;
                                end
                            end
                            `OP_AUTH:
                            begin
                                if (s.rx_cnt == `LEN_AUTH)
                                begin
                                    if (s.locked)
                                    begin
                                        next_s.code = `NAK_AUTH;
                                    end
                                    else if (pw_ok)
                                    begin
                                        next_s.authed = 1'b1;
                                        next_s.short_rep = 1'b0;
                                        next_s.tx_len = `LEN_PACK_REPLY;
                                    end
                                    else
                                    begin
                                        next_s.authed = 1'b0;
                                        next_s.code = `NAK_AUTH;
                                        if (limited)
                                        begin
                                            next_s.pend = P_FAIL;
                                        end
                                    end
                                end
                            end
                            `OP_SIG:
                            begin
                                if (s.rx_cnt == `LEN_IDX
                                    && s.rx[1] == `SIG_ARG)
                                begin
                                    next_s.short_rep = 1'b0;
                                    next_s.tx_len = `LEN_SIG_REPLY;
                                end
                            end
                            `OP_TEAR:
                            begin
                                if (s.rx_cnt == `LEN_IDX && idx_ok)
                                begin
                                    next_s.short_rep = 1'b0;
                                end
                            end
                            `OP_VCS:
                            begin
                                if (s.rx_cnt == `LEN_VCS)
                                begin
                                    next_s.short_rep = 1'b0;
                                end
                            end
                            default:
                            begin
                                next_s.code = `NAK_ARG;
                            end
                        endcase
                    end
                end
            end
            C_WAIT:
            begin
                // turnaround; nonvolatile update lands at its end
                next_s.wait_cnt = s.wait_cnt + 4'h1;
                if (s.pf_sync[1])
                begin
                    // power lost mid-update: old value kept, no answer
                    if (s.pend == P_INCR)
                    begin
                        next_s.torn[ci] = 1'b1;
                    end
                    next_s.st = C_IDLE;
                    next_s.rx_cnt = 5'h00;
                end
                else if (s.wait_cnt == `TURN_MIN - 4'h1)
                begin
                    if (s.pend == P_INCR)
                    begin
                        next_s.cnt[ci] = s.new_val;
                        next_s.torn[ci] = 1'b0;
                    end
                    else if (s.pend == P_FAIL)
                    begin
                        next_s.fail_cnt = s.fail_cnt + 3'h1;
                    end
                    next_s.st = C_SEND;
                    next_s.tx_idx = 6'h00;
                    next_s.gap = 1'b0;
                end
            end
            C_SEND:
            begin
                // one byte every second link cycle
                next_s.gap = !s.gap;
                if (!s.gap)
                begin
                    next_s.dout = s.short_rep ? {4'h0, s.code} : rb;
                    next_s.dshort = s.short_rep;
                    next_s.dlast = s.short_rep
                                   || (s.tx_idx == s.tx_len - 6'h01);
                    next_s.tog = !s.tog;
                    next_s.tx_idx = s.tx_idx + 6'h01;
                end
                else if (s.dlast)
                begin
                    next_s.st = C_IDLE;
                    next_s.rx_cnt = 5'h00;
                end
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////
    // state register; field reset spares nonvolatile fields
    always_ff @(posedge link.link_clk)
    begin
        if (link.field_rst)
        begin
            s <= '0;
            s.st <= C_IDLE;
            s.pend <= P_NONE;
            s.cnt <= next_s.cnt;
            s.torn <= next_s.torn;
            s.fail_cnt <= next_s.fail_cnt;
        end
        else
        begin
            s <= next_s;
        end
    end

endmodule : ticket_card

// file: ticket_reader.sv
// Purpose: reader end: sends a command frame, collects the answer
// Assumes: ref_clk 10 MHz, link clock is ref_clk divided by two
// Notes: card bytes cross by toggle through two flops
`timescale 1ns/1ps
`include "ticket_cfg.svh"
module ticket_reader
    import ticket_pkg::*;
#(
    parameter int unsigned TIMEOUT_CYCLES = `TIMEOUT_US * `REF_MHZ
)
(
    input wire logic ref_clk,
    input wire logic rst,
    ticket_link_if.reader link,
    input wire logic cmd_valid,
    output logic cmd_ready,
    input wire logic [4:0] cmd_len,
    input wire rx_buf_t cmd_bytes,
    input wire logic cmd_crc_error,
    output logic resp_valid,
    output logic resp_short,
    output logic [3:0] resp_code,
    output logic [5:0] resp_len,
    output sig_t resp_data,
    output logic resp_timeout
);

    ////////////////////////////////////////////////////////////////////
    // state
    reader_t s;       // registered state
    reader_t next_s;  // next state

    assign link.link_clk = s.lclk;
    assign link.field_rst = s.frst;
    assign link.rd_valid = s.rdv;
    assign link.rd_data = s.rdd;
    assign link.rd_end = s.rde;
    assign link.rd_crc_err = s.rdc;
    assign cmd_ready = s.ready;
    assign resp_valid = s.rvalid;
    assign resp_short = s.rshort;
    assign resp_code = s.rcode;
    assign resp_len = s.rlen;
    assign resp_data = s.rdata;
    assign resp_timeout = s.rtimeout;

    ////////////////////////////////////////////////////////////////////
    // next-state logic
    always_comb
    begin
        logic fall;   // link clock falls at this edge
        logic got;    // a new card byte has crossed
        next_s = s;
        fall = s.lclk;
        got = s.tog_sync[2] ^ s.tog_sync[1];
        next_s.lclk = !s.lclk;
        next_s.tog_sync = {s.tog_sync[1:0], link.dv_tog};
        next_s.rvalid = 1'b0;
        next_s.ready = 1'b0;

        // field reset held for some ref_clk cycles after release
        if (s.frst_cnt != `FIELD_RST_LEN)
        begin
            next_s.frst_cnt = s.frst_cnt + 3'h1;
        end
        next_s.frst = (s.frst_cnt != `FIELD_RST_LEN);

        unique case (s.st)
            R_IDLE:
            begin
                next_s.ready = !s.frst;
                if (s.ready && cmd_valid)
                begin
                    next_s.ready = 1'b0;
                    next_s.cbuf = cmd_bytes;
                    next_s.len = cmd_len;
                    next_s.crc_bad = cmd_crc_error;
                    next_s.idx = 5'h00;
                    next_s.st = R_SEND;
                end
            end
            R_SEND:
            begin
                // outputs change on falling link edges only
                if (fall)
                begin
                    next_s.rdv = 1'b0;
                    next_s.rde = 1'b0;
                    if (s.idx < s.len)
                    begin
                        next_s.rdv = 1'b1;
                        next_s.rdd = s.cbuf[s.idx];
                        next_s.idx = s.idx + 5'h01;
                    end
                    else if (!s.rde)
                    begin
                        next_s.rde = 1'b1;
                        next_s.rdc = s.crc_bad;
                    end
                    else
                    begin
                        next_s.st = R_WAIT;
                        next_s.tmo = 32'h0;
                        next_s.rlen = 6'h00;
                        next_s.rshort = 1'b0;
                        next_s.rtimeout = 1'b0;
                        next_s.rcode = 4'h0;
                    end
                end
            end
            R_WAIT:
            begin
                // collect answer bytes until last or timeout
                next_s.tmo = s.tmo + 32'h1;
                if (got)
                begin
                    next_s.rdata[s.rlen[4:0]] = link.dv_data;
                    next_s.rlen = s.rlen + 6'h01;
                    next_s.rshort = link.dv_short;
                    next_s.rcode = link.dv_data[3:0];
                    if (link.dv_last)
                    begin
                        next_s.rvalid = 1'b1;
                        next_s.st = R_IDLE;
                    end
                end
                else if (s.tmo == TIMEOUT_CYCLES - 1)
                begin
                    next_s.rtimeout = 1'b1;
                    next_s.rvalid = 1'b1;
                    next_s.st = R_IDLE;
                end
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////
    // state register
    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            s <= '0;
            s.st <= R_IDLE;
            s.frst <= 1'b1;
        end
        else
        begin
            s <= next_s;
        end
    end

endmodule : ticket_reader

// file: ticket_link_props.sv
// Purpose: link checks between reader and card
// Assumes: sees the link signals only
// Notes: one clock domain, link_clk
`timescale 1ns/1ps
`include "ticket_cfg.svh"
module ticket_link_props
(
    input wire logic link_clk,
    input wire logic field_rst,
    input wire logic rd_valid,
    input wire logic [7:0] rd_data,
    input wire logic rd_end,
    input wire logic rd_crc_err,
    input wire logic dv_tog,
    input wire logic [7:0] dv_data,
    input wire logic dv_short,
    input wire logic dv_last
);
    logic [4:0] n, n_f;  // byte count, last frame length
    logic [7:0] op, arg;  // last opcode, first argument
    logic crc_f, tog_q, nb, ok;  // crc flag, old toggle, new byte
    logic [3:0] c;  // answer code
    assign nb = dv_tog != tog_q;
    assign ok = nb && !crc_f;
    assign c = dv_data[3:0];
    default clocking cb @(posedge link_clk); endclocking
    default disable iff (field_rst);
    ////////////////////////////////////////////////////////////
    // record the shape of each frame
    always_ff @(posedge link_clk)
    begin
        tog_q <= dv_tog;
        n <= (field_rst || rd_end) ? 5'h00 : n + 5'(rd_valid);
        if (rd_valid && n == 5'h00) op <= rd_data;
        if (rd_valid && n == 5'h01) arg <= rd_data;
        if (rd_end) n_f <= n;
        if (rd_end) crc_f <= rd_crc_err;
    end
    property p_turn; rd_end |=> !nb [*8]; endproperty
    a_turn: assert property (p_turn) else $error("early answer");
    property p_gap; nb && !dv_last |=> !nb ##1 nb; endproperty
    a_gap: assert property (p_gap) else $error("byte gap");
    property p_crc; nb && crc_f |-> dv_short && c == `NAK_CRC; endproperty
    a_crc: assert property (p_crc) else $error("crc answer");
    property p_sig; ok && op == `OP_SIG && !dv_short |-> dv_data == 8'h5A;
    endproperty
    a_sig: assert property (p_sig) else $error("signature byte");
    property p_idx; ok && op inside {`OP_INCR, `OP_TEAR, `OP_COUNTER_READ_CMD} &&
        arg > `CNT_IDX_MAX |-> dv_short && c == `NAK_ARG; endproperty
    a_idx: assert property (p_idx) else $error("index answer");
    property p_vcs; ok && op == `OP_VCS |-> dv_short == (n_f != `LEN_VCS);
    endproperty
    a_vcs: assert property (p_vcs) else $error("select length");
    property p_incr; ok && op == `OP_INCR |->
        dv_short && c inside {`ACK_CODE, `NAK_ARG}; endproperty
    a_incr: assert property (p_incr) else $error("increment answer");
    property p_one; ok && op inside {`OP_TEAR, `OP_VCS} && !dv_short
        |-> dv_last; endproperty
    a_one: assert property (p_one) else $error("one byte answer");
endmodule : ticket_link_props

// file: testbench.sv
// Purpose: reader and card joined, commands checked end to end
// Assumes: reader makes link clock and field reset
// Notes: short reader timeout keeps the run brief
`timescale 1ns/1ps
`include "ticket_cfg.svh"
module testbench
    import ticket_pkg::*;
;
    logic ref_clk = 0, rst = 1, cmd_valid = 0, cmd_crc_error = 0;
    logic [4:0] cmd_len = '0;
    rx_buf_t cmd_bytes = '0;
    logic cmd_ready, resp_valid, resp_short, resp_timeout, qr, qw, au, lk;
    logic [3:0] resp_code;
    logic [5:0] resp_len;
    sig_t resp_data;
    logic factory_clear = 1, power_fail = 0, scope = 1;  // card inputs
    logic [7:0] query_page = 8'h0A;
    logic [31:0] pw = 32'h44332211;
    logic [2:0] tf;
    int n_mismatch = 0, cmp_count = 0;
    ticket_link_if li ();
    ticket_reader #(.TIMEOUT_CYCLES(400)) ticket_reader_inst (.ref_clk,
        .rst, .link(li.reader), .cmd_valid, .cmd_ready, .cmd_len,
        .cmd_bytes, .cmd_crc_error, .resp_valid, .resp_short, .resp_code,
        .resp_len, .resp_data, .resp_timeout);
    ticket_card ticket_card_inst (.link(li.card), .factory_clear,
        .power_fail, .protection_start_page(8'h04),
        .protection_scope_bit(scope), .failed_attempt_limit(3'h2),
        .password(pw), .pack(16'hBBAA), .virtual_card_type(8'h5C),
        .query_page, .query_read_ok(qr), .query_write_ok(qw),
        .authenticated(au), .access_locked(lk), .tear_flags(tf));
    ticket_link_props ticket_link_props_inst (.link_clk(li.link_clk),
        .field_rst(li.field_rst), .rd_valid(li.rd_valid),
        .rd_data(li.rd_data), .rd_end(li.rd_end), .rd_crc_err(li.rd_crc_err),
        .dv_tog(li.dv_tog), .dv_data(li.dv_data), .dv_short(li.dv_short),
        .dv_last(li.dv_last));
    always #50 ref_clk = ~ref_clk;
    task tick;
        @(posedge ref_clk);
        #1;
    endtask : tick
    task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("Error %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    task give_verdict;
        $display("compares %0d mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : give_verdict
    // send one frame for one cycle once the reader is ready, wait for the answer
    task send(input logic [4:0] len, input logic [47:0] b, input logic e = 0);
        int i;
        for (i = 0; i < 900 && cmd_ready !== 1'h1; i++) tick;
        cmd_len = len;
        cmd_bytes = rx_buf_t'(b);
        cmd_crc_error = e;
        cmd_valid = 1'h1;
        tick;
        cmd_valid = 1'h0;
        for (i = 0; i < 900 && resp_valid !== 1'h1; i++) tick;
        chk("resp_valid", resp_valid, 1);
    endtask : send
    task code(input logic [3:0] c);
        chk("code", {resp_short, resp_code}, {1'h1, c});
    endtask : code
    task cnt(input logic [7:0] idx, input logic [23:0] exp);
        send(2, {32'h0, idx, 8'h39});
        chk("counter", resp_data[2:0], exp);
    endtask : cnt
    initial
    begin
        repeat (20) tick;
        rst = 0;
        repeat (30) tick;
        factory_clear = 0;
        send(6, 48'hFF_03_02_01_00_A5);
        code(`ACK_CODE);
        cnt(0, 24'h030201);
        send(6, 48'h00_FC_FD_FE_00_A5);
        code(`ACK_CODE);
        send(6, 48'h00_00_00_01_00_A5);
        code(`NAK_ARG);
        send(6, 48'h00_00_00_00_00_A5);
        code(`ACK_CODE);
        cnt(0, 24'hFFFFFF);
        send(6, 48'h01_03_A5);
        code(`NAK_ARG);
        send(6, 48'h01_01_A5, 1);
        code(`NAK_CRC);
        cnt(1, 24'h0);
        power_fail = 1;
        send(6, 48'h05_01_A5);
        power_fail = 0;
        chk("torn", {resp_timeout, tf}, 4'hA);
        send(2, 48'h01_3E);
        chk("tear", resp_data[0], `TEAR_BAD);
        cnt(1, 24'h0);
        send(2, 48'h00_3E);
        chk("tear", resp_data[0], `TEAR_OK);
        chk("access", {qr, qw}, 0);
        send(5, 48'h1B);
        code(`NAK_AUTH);
        send(5, {8'h0, pw, 8'h1B});
        chk("pack", {resp_short, resp_data[1:0]}, 17'hBBAA);
        chk("access", {au, qr, qw}, 3'h7);
        send(5, 48'h1B);
        code(`NAK_AUTH);
        send(5, 48'h1B);
        code(`NAK_AUTH);
        send(5, {8'h0, pw, 8'h1B});
        code(`NAK_AUTH);
        chk("locked", {lk, qr}, 2'h2);
        cnt(0, 24'hFFFFFF);
        send(2, 48'h3C);
        chk("sig", {resp_len, resp_data[31], resp_data[0]}, 22'h205A5A);
        send(2, 48'h01_3C);
        code(`NAK_ARG);
        send(21, 48'h4B);
        chk("type", {resp_short, resp_len, resp_data[0]}, 15'h015C);
        send(20, 48'h4B);
        code(`NAK_ARG);
        scope = 0;
        repeat (4) tick;
        chk("access", {qr, qw}, 2'h2);
        query_page = 8'h02;
        repeat (4) tick;
        chk("access", {qr, qw}, 2'h3);
        give_verdict;
    end
    initial
    begin
        #3000000;
        n_mismatch++;
        give_verdict;
    end
endmodule : testbench
